//--- design/flash_host_ctrl.sv
// Host controller that drives a parallel NOR flash over its strobes.
// Assumes one 10 MHz clock; flash data and status pins are asynchronous.
// Operation
// - Reads keep write strobe and reset high during select and enable.
// - Host never asserts output enable and write strobe together.
// - Host presents block or location address for erase and program.
// - Host holds device in reset across supply ramps.
`timescale 1ns/10ps
`include "flash_host_params.svh"
module flash_host_ctrl #(
   parameter int RST_LOW_CYCLES = `RST_LOW_CYC
) (
   input  wire logic                         clk_sys,
   input  wire logic                         arst_n,
   // User side
   input  wire logic                         reqValid,
   output      logic                         reqReady,
   input  wire flash_host_pkg::host_req_s    req,
   input  wire logic                         powerHold,
   input  wire logic                         flashReset,
   output      logic                         rspValid,
   output      logic [`DATA_W-1:0]           rspData,
   output      logic                         flashBusy,
   output      logic                         flashReady,
   // Flash pins
   output      flash_host_pkg::flash_ctrl_s  pins,
   input  wire logic [`DATA_W-1:0]           dataIn,
   output      logic [`DATA_W-1:0]           dataOut,
   output      logic                         dataOeN,
   input  wire logic                         status_ready_pin
);

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   flash_host_pkg::host_state_e  state_reg, state_next;
   logic [`CNT_W-1:0]            cnt_reg, cnt_next;
   flash_host_pkg::host_req_s    req_reg;
   logic [`DATA_W-1:0]           rdata_reg;
   logic                         rspValid_reg;
   logic [1:0]                   dataSync_en;
   logic [`DATA_W-1:0]           dataSync1_reg, dataSync2_reg;
   logic                         stsSync1_reg, stsSync2_reg;

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   // Hold in reset while supplies ramp or user asks for it
   wire holdReset = powerHold | flashReset;
   wire cntDone   = (cnt_reg == '0);
   wire take      = reqValid & reqReady;
   wire inRead    = (state_reg == flash_host_pkg::ST_READ);
   wire inWrite   = (state_reg == flash_host_pkg::ST_WRITE);
   wire selected  = inRead | inWrite;
   // Counter loads; every timed state counts down to zero before moving on, unless a reset request aborts it
   wire [`CNT_W-1:0] recLoad  = `CNT_W'(`RST_RECOVER_CYC);
   wire [`CNT_W-1:0] readLoad = `CNT_W'(`READ_ACC_CYC + `SYNC_CYC);
   wire [`CNT_W-1:0] wrLoad   = `CNT_W'(`WRITE_LOW_CYC);
   wire [`CNT_W-1:0] gapLoad  = `CNT_W'(`GAP_CYC);
   wire [`CNT_W-1:0] rstLoad  = `CNT_W'(RST_LOW_CYCLES);

   // Low byte only in byte mode; upper lanes zeroed
   wire [`DATA_W-1:0] readData = req_reg.byteMode ?
        {8'h00, dataSync2_reg[7:0]} : dataSync2_reg;

   // Handshake and status; ready only when idle and no reset is asked
   assign reqReady   = (state_reg == flash_host_pkg::ST_IDLE) & ~holdReset;
   assign rspValid   = rspValid_reg;
   assign rspData    = rdata_reg;
   assign flashBusy  = ~stsSync2_reg;
   assign flashReady = reqReady;

   // Pin drive: reset dominates every other strobe
   assign pins.resetN  = (state_reg != flash_host_pkg::ST_RESET);
   assign pins.chipSel = selected ? `CS_SELECT : `CS_DESELECT;
   // Output enable only in read; never overlaps the write strobe
   assign pins.outEnN  = ~inRead;
   assign pins.writeN  = ~(inWrite & ~cntDone);
   assign pins.byteSel = ~req_reg.byteMode;
   assign pins.addr    = req_reg.addr;
   assign dataOut      = req_reg.wdata;
   assign dataOeN      = ~inWrite;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Cycle walk, counted from the edge that takes a request:
   //   read:  select and output enable drop together and stand for one
   //          cycle more than the access time plus the synchroniser stages; the last read
   //          cycle captures the bus and rspValid pulses one cycle
   //          later, while the gap already runs.
   //   write: select, strobe and data drive start together; the strobe
   //          rises one cycle before select drops, so address and data
   //          are still held at the edge that latches them.
   //   reset: powerHold or flashReset abandons any cycle at once; a cut
   //          program leaves its target undefined, and the caller must
   //          rewrite it after recovery.
   always_comb begin
      state_next = state_reg;
      cnt_next   = cntDone ? cnt_reg : cnt_reg - 1'b1;
      unique case (state_reg)
         flash_host_pkg::ST_RESET: begin
            if (cntDone && !holdReset) begin
               state_next = flash_host_pkg::ST_RECOVER;
               cnt_next   = recLoad;
            end
         end
         flash_host_pkg::ST_RECOVER: begin
            // No access until the device has woken from reset
            if (cntDone)
               state_next = flash_host_pkg::ST_IDLE;
         end
         flash_host_pkg::ST_IDLE: begin
            if (take) begin
               state_next = req.write ? flash_host_pkg::ST_WRITE
                                      : flash_host_pkg::ST_READ;
               cnt_next   = req.write ? wrLoad : readLoad;
            end
         end
         flash_host_pkg::ST_READ: begin
            // Extra cycles cover the data synchroniser
            if (cntDone) begin
               state_next = flash_host_pkg::ST_GAP;
               cnt_next   = gapLoad;
            end
         end
         flash_host_pkg::ST_WRITE: begin
            // Strobe low time; select stays one cycle longer
            if (cntDone) begin
               state_next = flash_host_pkg::ST_GAP;
               cnt_next   = gapLoad;
            end
         end
         flash_host_pkg::ST_GAP: begin
            // Recovery before the next cycle, write-to-read included
            if (cntDone)
               state_next = flash_host_pkg::ST_IDLE;
         end
         default: begin
            // Illegal code: fall back to a full reset pulse
            state_next = flash_host_pkg::ST_RESET;
            cnt_next   = rstLoad;
         end
      endcase
      // Reset request outside ST_RESET aborts any cycle and restarts the pulse timer
      if (holdReset && state_reg != flash_host_pkg::ST_RESET) begin
         state_next = flash_host_pkg::ST_RESET;
         cnt_next   = rstLoad;
      end
   end

   // ------------------------------------------------------------------
   // State and counter
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= flash_host_pkg::ST_RESET;
         cnt_reg   <= `CNT_W'(RST_LOW_CYCLES);
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Capture request; fields stay stable through the whole cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n)
         req_reg <= '0;
      else if (take)
         req_reg <= req;
   end

   // ------------------------------------------------------------------
   // Synchronisers and read capture
   // ------------------------------------------------------------------
   // Data bus and status pin are asynchronous to clk_sys
   // The bus is synchronised bit by bit; safe only because it has
   // settled for several cycles before the capture cycle reads it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dataSync1_reg <= '0;
         dataSync2_reg <= '0;
         stsSync1_reg  <= 1'b1;
         stsSync2_reg  <= 1'b1;
      end else begin
         dataSync1_reg <= dataIn;
         dataSync2_reg <= dataSync1_reg;
         stsSync1_reg  <= status_ready_pin;
         stsSync2_reg  <= stsSync1_reg;
      end
   end

   // Capture strobe: inside a read, on its last cycle
   assign dataSync_en = {inRead, cntDone};

   // Sample at the last read cycle, after access time plus sync
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg    <= '0;
         rspValid_reg <= 1'b0;
      end else begin
         rspValid_reg <= (dataSync_en == 2'h3) & ~holdReset;
         if (dataSync_en == 2'h3)
            rdata_reg <= readData;
      end
   end

endmodule // flash_host_ctrl

//--- design/flash_host_params.svh
// Constants for the parallel flash host controller.
// Assumes a 10 MHz system clock; all counts except SYNC_CYC derive from it.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define CLK_PERIOD_NS      100
`define ADDR_W             24
`define DATA_W             16
// Reset pulse low time, worst case, in ns
`define RST_LOW_NS         35000
`define RST_LOW_CYC        ((`RST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Recovery after reset before first access, in ns
`define RST_RECOVER_NS     210
`define RST_RECOVER_CYC    ((`RST_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Read access time, in ns
`define READ_ACC_NS        150
`define READ_ACC_CYC       ((`READ_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Synchroniser stages the read data crosses before capture
`define SYNC_CYC           2
// Write strobe low time, in ns
`define WRITE_LOW_NS       70
`define WRITE_LOW_CYC      ((`WRITE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Recovery between cycles (write high / write-to-read), in ns
`define GAP_NS             35
`define GAP_CYC            ((`GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              16
// Chip select pattern that selects the device: c=0, b=0, a=0
`define CS_SELECT          3'h0
`define CS_DESELECT        3'h7

`endif

//--- design/flash_host_pkg.sv
// Types shared by the flash host controller and its bench.
// Assumes flash_host_params.svh is on the include path.
`include "flash_host_params.svh"
package flash_host_pkg;
   typedef enum logic [2:0] {
      ST_RESET   = 3'h0,
      ST_RECOVER = 3'h1,
      ST_IDLE    = 3'h3,
      ST_READ    = 3'h2,
      ST_WRITE   = 3'h6,
      ST_GAP     = 3'h7
   } host_state_e;

   typedef struct packed {
      logic                  write;
      logic                  byteMode;
      logic [`ADDR_W-1:0]    addr;
      logic [`DATA_W-1:0]    wdata;
   } host_req_s;

   typedef struct packed {
      logic                  resetN;
      logic [2:0]            chipSel;
      logic                  outEnN;
      logic                  writeN;
      logic                  byteSel;
      logic [`ADDR_W-1:0]    addr;
   } flash_ctrl_s;
endpackage

//--- tb/flash_dev_model.sv
// Device model: decodes the pins, stores words, drives the data bus.
// Assumes the bench routes the host's write data in through busIn.
`timescale 1ns/10ps
module flash_dev_model (
   input  wire logic                        clk_sys,
   input  wire flash_host_pkg::flash_ctrl_s pins,
   input  wire logic [15:0]                 busIn,
   input  wire logic                        busOeN,
   output      logic [15:0]                 dataIn,
   output      logic                        status_ready_pin
);
   logic [15:0] mem [256];
   logic [15:0] last = 16'h0;
   logic [3:0]  busy = 4'h0;
   int          wrCount = 0, wrSeen = 0;
   logic [7:0]  a;
   // Three-pin select; reset overrides every strobe
   wire sel = pins.resetN && (pins.chipSel == 3'h0 ||
      (pins.chipSel[2] && pins.chipSel[1:0] != 2'h3));
   wire wr = sel && !pins.writeN;
   wire rd = sel && !pins.outEnN;
   assign a = pins.addr[7:0];
   // Released lines toggle so a stale value never passes
   assign dataIn = !busOeN ? busIn : !rd ? ~last :
      pins.byteSel ? mem[a] : {~last[15:8], mem[a][7:0]};
   assign status_ready_pin = busy == 4'h0 || !pins.resetN;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   // Latch when the strobe rises or the select drops
   always @(negedge wr) if (pins.resetN) begin
      mem[a] = pins.byteSel ? busIn : {mem[a][15:8], busIn[7:0]};
      wrCount++;
   end
   // Program starts at the clock after the latch; one writer for busy
   // avoids a race with the strobe edge; reset aborts, leaves ready
   always @(posedge clk_sys) begin
      last   <= dataIn;
      wrSeen <= wrCount;
      busy   <= !pins.resetN ? 4'h0 : wrSeen != wrCount ? 4'hc :
         busy == 4'h0 ? 4'h0 : busy - 4'h1;
   end
endmodule // flash_dev_model

//--- tb/flash_host_ctrl_assertions.sv
// Checker for the controller's strobes and user handshake.
// Assumes it is bound into every controller instance.
`timescale 1ns/10ps
module flash_host_ctrl_assertions #(
   parameter int RST_LOW_CYCLES = 350
) (
   input wire logic                        clk_sys,
   input wire logic                        arst_n,
   input wire logic                        reqValid,
   input wire logic                        reqReady,
   input wire flash_host_pkg::host_req_s   req,
   input wire logic                        powerHold,
   input wire logic                        flashReset,
   input wire logic                        rspValid,
   input wire logic [15:0]                 rspData,
   input wire flash_host_pkg::flash_ctrl_s pins,
   input wire logic                        dataOeN
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // Accepted requests of each kind
   wire takeRd = reqValid && reqReady && !req.write;
   wire takeWr = reqValid && reqReady && req.write;
   chk_no_overlap: assert property (!(!pins.outEnN && !pins.writeN))
      else $error("output enable and write strobe low together");
   chk_read_strobes: assert property (!pins.outEnN |-> pins.writeN &&
      pins.resetN && pins.chipSel == 3'h0) else $error("bad read strobes");
   chk_reset_quiet: assert property (!pins.resetN |-> pins.chipSel ==
      3'h7 && pins.outEnN && pins.writeN && dataOeN) else $error("reset busy");
   chk_reset_request: assert property ((flashReset || powerHold) |=>
      !pins.resetN) else $error("flash reset not driven");
   chk_read_latency: assert property (takeRd |=> pins.chipSel == 3'h0 &&
      !pins.outEnN ##5 rspValid) else $error("read walk broken");
   chk_write_walk: assert property (disable iff (!arst_n || flashReset)
      takeWr |=> !pins.writeN && !dataOeN && pins.chipSel == 3'h0 ##1
      pins.writeN && pins.chipSel == 3'h0 ##1 pins.chipSel == 3'h7)
      else $error("write walk broken");
   chk_byte_lane: assert property (rspValid && !pins.byteSel |->
      rspData[15:8] == 8'h00) else $error("upper byte not zero");
   chk_gap_ready: assert property (rspValid |-> pins.chipSel == 3'h7 &&
      !reqReady ##1 !reqReady ##1 reqReady) else $error("gap broken");
endmodule // flash_host_ctrl_assertions

bind flash_host_ctrl flash_host_ctrl_assertions #(
   .RST_LOW_CYCLES(RST_LOW_CYCLES)) chk (.clk_sys(clk_sys), .arst_n(arst_n),
   .reqValid(reqValid), .reqReady(reqReady), .req(req), .pins(pins),
   .powerHold(powerHold), .flashReset(flashReset), .rspValid(rspValid),
   .rspData(rspData), .dataOeN(dataOeN));

//--- tb/tb.sv
// Bench: random traffic, busy, abort and hold against a reference memory.
// Assumes the package, controller and device model are compiled first.
`timescale 1ns/10ps
module tb;
   logic clk_sys = 1'b0, arst_n = 1'b0, reqValid = 1'b0;
   logic powerHold = 1'b0, flashReset = 1'b0;
   logic reqReady, rspValid, flashBusy, flashReady, dataOeN, stsPin;
   logic [15:0] rspData, dataIn, dataOut;
   logic [15:0] expMem [256];
   flash_host_pkg::host_req_s   req = '0;
   flash_host_pkg::flash_ctrl_s pins;
   int miscompares = 0, samples_checked = 0, seed = 54, n;
   always #50 clk_sys = ~clk_sys;
   // Short reset pulse keeps the run brief
   flash_host_ctrl #(.RST_LOW_CYCLES(4)) DUT (.clk_sys(clk_sys),
      .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady), .req(req),
      .powerHold(powerHold), .flashReset(flashReset), .rspValid(rspValid),
      .rspData(rspData), .flashBusy(flashBusy), .flashReady(flashReady),
      .pins(pins), .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN),
      .status_ready_pin(stsPin));
   flash_dev_model partner (.clk_sys(clk_sys), .pins(pins), .busIn(dataOut),
      .busOeN(dataOeN), .dataIn(dataIn), .status_ready_pin(stsPin));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic bail();
      miscompares++;
      final_report();
   endtask
   // One request, held until taken; reads compared with the reference
   task automatic xfer(input logic w, input logic b, input logic [7:0] a,
                       input logic [15:0] d);
      @(negedge clk_sys);
      reqValid = 1'b1;
      req = '{w, b, {16'h0, a}, d};
      for (n = 0; n < 900 && reqReady !== 1'b1; n++) @(negedge clk_sys);
      @(negedge clk_sys);
      reqValid = 1'b0;
      if (n == 900) bail();
      if (w) expMem[a] = b ? {expMem[a][15:8], d[7:0]} : d;
      else begin
         for (n = 0; n < 20 && rspValid !== 1'b1; n++) @(negedge clk_sys);
         if (n == 20) bail();
         check(rspData, b ? {8'h00, expMem[a][7:0]} : expMem[a]);
      end
   endtask
   initial begin
      foreach (expMem[i]) expMem[i] = 16'hffff;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      // Few addresses so reads hit earlier writes of both widths
      repeat (60) xfer(1'($random(seed)), 1'($random(seed)),
         {4'h0, 4'($random(seed))}, 16'($random(seed)));
      xfer(1'b1, 1'b0, 8'hff, 16'h1234);
      repeat (5) @(negedge clk_sys);
      check({15'h0, flashBusy}, 16'h1);
      flashReset = 1'b1;
      repeat (3) @(negedge clk_sys);
      check({15'h0, pins.resetN}, 16'h0);
      check({15'h0, stsPin}, 16'h1);
      flashReset = 1'b0;
      powerHold = 1'b1;
      repeat (6) @(negedge clk_sys);
      check({15'h0, pins.resetN}, 16'h0);
      check({15'h0, flashReady}, 16'h0);
      powerHold = 1'b0;
      xfer(1'b0, 1'b0, 8'h05, 16'h0);
      repeat (3) @(negedge clk_sys);
      check({15'h0, flashReady}, 16'h1);
      final_report();
   end
endmodule // tb
